//--- core/gdfsb_regs.svh
// Purpose: register offsets, field positions and reset values of the fault status bank
// Assumes: word addresses on the plain register port
// Notes:   definitions only
`ifndef GDFSB_REGS_SVH
`define GDFSB_REGS_SVH

`define GDFSB_AW            4
`define GDFSB_DW            11
`define GDFSB_ADDR_STATUS   4'h0
`define GDFSB_ADDR_CTRL     4'h2
`define GDFSB_ADDR_AMP      4'h6
`define GDFSB_ADDR_CAL      4'h7
`define GDFSB_ADDR_IRQ_STAT 4'h8
`define GDFSB_ADDR_IRQ_MASK 4'h9
`define GDFSB_BIT_SUMMARY   10
`define GDFSB_BIT_VDS       9
`define GDFSB_BIT_GATE      8
`define GDFSB_BIT_LOW_SUPPLY 7
`define GDFSB_BIT_HEAT      6
`define GDFSB_BIT_CLR       0
`define GDFSB_NSW           6
`define GDFSB_NEV           5
`define GDFSB_RST_FLAGS     11'h000
`define GDFSB_RST_WORD      11'h000
`define GDFSB_RST_EV        5'h00
`define GDFSB_ZERO_WORD     11'h000

`endif

//--- core/gdfsb_pkg.sv
// Purpose: shared types of the fault status bank
// Assumes: header holds all numbers
// Notes:   none
`include "gdfsb_regs.svh"
package gdfsb_pkg;
  typedef logic [`GDFSB_DW-1:0]  gdfsb_word_t;
  typedef logic [`GDFSB_AW-1:0]  gdfsb_addr_t;
  typedef logic [`GDFSB_NSW-1:0] gdfsb_sw_t;
  typedef logic [`GDFSB_NEV-1:0] gdfsb_ev_t;
endpackage : gdfsb_pkg

//--- core/gdfsb_ev_if.sv
// Purpose: carries detector events and clear strobe between bank and latch
// Assumes: single clock
// Notes:   none
`timescale 1ns/1ps
interface gdfsb_ev_if;
  import gdfsb_pkg::*;
  gdfsb_sw_t   sw_oc;
  logic        gate_err;
  logic        low_supply;
  logic        heat;
  logic        clear;
  gdfsb_word_t flags;
  modport bank  (output sw_oc, output gate_err, output low_supply, output heat, output clear,
                 input flags);
  modport latch (input sw_oc, input gate_err, input low_supply, input heat, input clear,
                 output flags);
endinterface : gdfsb_ev_if

//--- core/gdfsb_latch.sv
// Purpose: latched error flags of the first status word
// Assumes: detector inputs synchronous
// Notes:   a new event in the clear cycle survives
`timescale 1ns/1ps
`include "gdfsb_regs.svh"
module gdfsb_latch (
  // clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   nrst_i,
  // events and flags
  gdfsb_ev_if.latch   ev
);
  import gdfsb_pkg::*;

  typedef struct packed {
    gdfsb_word_t flags;
  } gdfsb_latch_s;

  gdfsb_latch_s s_q;
  gdfsb_latch_s s_d;
  gdfsb_word_t  set_w;
  gdfsb_word_t  hold_w;

  always_comb begin
    set_w = `GDFSB_ZERO_WORD;
    set_w[`GDFSB_NSW-1:0]    = ev.sw_oc;
    set_w[`GDFSB_BIT_VDS]    = |ev.sw_oc;
    set_w[`GDFSB_BIT_GATE]   = ev.gate_err;
    set_w[`GDFSB_BIT_LOW_SUPPLY] = ev.low_supply;
    set_w[`GDFSB_BIT_HEAT]   = ev.heat;
    hold_w = ev.clear ? `GDFSB_ZERO_WORD : s_q.flags;
    s_d.flags = hold_w | set_w;
    s_d.flags[`GDFSB_BIT_SUMMARY] = |s_d.flags[`GDFSB_BIT_SUMMARY-1:0];
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.flags <= `GDFSB_RST_FLAGS;
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.flags = s_q.flags;
endmodule : gdfsb_latch

//--- core/gdfsb_irq.sv
// Purpose: sticky event status, mask and one level interrupt
// Assumes: write-one-to-clear status
// Notes:   set wins over clear
`timescale 1ns/1ps
`include "gdfsb_regs.svh"
module gdfsb_irq (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // events and software access
  input  wire gdfsb_pkg::gdfsb_ev_t ev_i,
  input  wire logic              clr_we_i,
  input  wire gdfsb_pkg::gdfsb_ev_t clr_i,
  input  wire logic              mask_we_i,
  input  wire gdfsb_pkg::gdfsb_ev_t mask_i,
  // state
  output      gdfsb_pkg::gdfsb_ev_t stat_o,
  output      gdfsb_pkg::gdfsb_ev_t mask_o,
  output      logic              irq_o
);
  import gdfsb_pkg::*;

  typedef struct packed {
    gdfsb_ev_t stat;
    gdfsb_ev_t mask;
    logic      irq;
  } gdfsb_irq_s;

  gdfsb_irq_s s_q;
  gdfsb_irq_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.stat = (s_q.stat & ~(clr_we_i ? clr_i : `GDFSB_RST_EV)) | ev_i;
    if (mask_we_i) begin
      s_d.mask = mask_i;
    end
    s_d.irq  = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat_o = s_q.stat;
  assign mask_o = s_q.mask;
  assign irq_o  = s_q.irq;
endmodule : gdfsb_irq

//--- core/gdfsb_top.sv
// Purpose: fault status register bank of a three-phase gate driver
// Assumes: register port single-cycle strobes, read data one cycle later
// Notes:   amplifier words are plain storage
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "gdfsb_regs.svh"
module gdfsb_top (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // register port
  input  wire gdfsb_pkg::gdfsb_addr_t reg_addr_i,
  input  wire gdfsb_pkg::gdfsb_word_t reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output      gdfsb_pkg::gdfsb_word_t reg_rdata_o,
  // protection detectors
  input  wire gdfsb_pkg::gdfsb_sw_t   switch_overcurrent_i,
  input  wire logic                  gate_drive_error_i,
  input  wire logic                  supply_low_lockout_i,
  input  wire logic                  overheat_shutdown_i,
  // indicators
  output      logic                  error_indicator_pin_n_o,
  output      logic                  irq_o
);
  import gdfsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    gdfsb_word_t rdata;
    gdfsb_word_t amp;
    gdfsb_word_t cal;
    logic        pin_n;
  } gdfsb_top_s;

  gdfsb_top_s  s_q;
  gdfsb_top_s  s_d;
  gdfsb_ev_if  ev ();
  gdfsb_ev_t   irq_stat;
  gdfsb_ev_t   irq_mask;
  gdfsb_ev_t   events;
  logic        irq_w;
  logic        wr_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // detectors into the latch
  assign ev.sw_oc    = switch_overcurrent_i;
  assign ev.gate_err = gate_drive_error_i;
  assign ev.low_supply = supply_low_lockout_i;
  assign ev.heat     = overheat_shutdown_i;
  assign wr_ctrl     = reg_we_i && (reg_addr_i == `GDFSB_ADDR_CTRL);
  // clear pulses one cycle only, never stored
  assign ev.clear    = wr_ctrl && reg_wdata_i[`GDFSB_BIT_CLR];

  gdfsb_latch u_latch (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ev         (ev.latch)
  );

  assign events = {|switch_overcurrent_i, gate_drive_error_i, supply_low_lockout_i,
                   overheat_shutdown_i, ev.flags[`GDFSB_BIT_SUMMARY]};

  gdfsb_irq u_irq (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ev_i       (events),
    .clr_we_i   (reg_we_i && (reg_addr_i == `GDFSB_ADDR_IRQ_STAT)),
    .clr_i      (reg_wdata_i[`GDFSB_NEV-1:0]),
    .mask_we_i  (reg_we_i && (reg_addr_i == `GDFSB_ADDR_IRQ_MASK)),
    .mask_i     (reg_wdata_i[`GDFSB_NEV-1:0]),
    .stat_o     (irq_stat),
    .mask_o     (irq_mask),
    .irq_o      (irq_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d       = s_q;
    s_d.pin_n = ~ev.flags[`GDFSB_BIT_SUMMARY];
    // status word has no write path
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `GDFSB_ADDR_AMP: begin
          s_d.amp = reg_wdata_i;
        end
        `GDFSB_ADDR_CAL: begin
          s_d.cal = reg_wdata_i;
        end
        default: begin
          s_d.amp = s_q.amp;
        end
      endcase
    end
    s_d.rdata = `GDFSB_ZERO_WORD;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `GDFSB_ADDR_STATUS:   s_d.rdata = ev.flags;
        `GDFSB_ADDR_AMP:      s_d.rdata = s_q.amp;
        `GDFSB_ADDR_CAL:      s_d.rdata = s_q.cal;
        `GDFSB_ADDR_IRQ_STAT: s_d.rdata = {{(`GDFSB_DW-`GDFSB_NEV){1'b0}}, irq_stat};
        `GDFSB_ADDR_IRQ_MASK: s_d.rdata = {{(`GDFSB_DW-`GDFSB_NEV){1'b0}}, irq_mask};
        default:              s_d.rdata = `GDFSB_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.rdata <= `GDFSB_RST_WORD;
      s_q.amp   <= `GDFSB_RST_WORD;
      s_q.cal   <= `GDFSB_RST_WORD;
      s_q.pin_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o             = s_q.rdata;
  assign error_indicator_pin_n_o = s_q.pin_n;
  assign irq_o                   = irq_w;
endmodule : gdfsb_top

//--- testbench/gdfsb_assertions.sv
// Purpose: port checks of the fault status bank
// Assumes: registered read data and pin
// Notes:   bound to the top
`timescale 1ns/1ps
module gdfsb_assertions (
  // clock and reset
  input wire logic                   core_clk_i,
  input wire logic                   nrst_i,
  // register port
  input wire gdfsb_pkg::gdfsb_addr_t reg_addr_i,
  input wire gdfsb_pkg::gdfsb_word_t reg_wdata_i,
  input wire logic                   reg_we_i,
  input wire logic                   reg_re_i,
  input wire gdfsb_pkg::gdfsb_word_t reg_rdata_o,
  // detectors and pin
  input wire gdfsb_pkg::gdfsb_sw_t   switch_overcurrent_i,
  input wire logic                   gate_drive_error_i,
  input wire logic                   supply_low_lockout_i,
  input wire logic                   overheat_shutdown_i,
  input wire logic                   error_indicator_pin_n_o
);
  import gdfsb_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire ev_w = |switch_overcurrent_i | gate_drive_error_i | supply_low_lockout_i
              | overheat_shutdown_i;
  wire clr_w = reg_we_i & (reg_addr_i == 4'h2) & reg_wdata_i[0];
  wire rd0_w = reg_re_i & (reg_addr_i == 4'h0);
  sequence s_ev_kept; ev_w ##1 !clr_w; endsequence
  property p_ev_pin; s_ev_kept |=> !error_indicator_pin_n_o; endproperty
  a_ev_pin: assert property (p_ev_pin) else $error("pin high after event");
  property p_mirror; rd0_w |=> reg_rdata_o[10] == !error_indicator_pin_n_o; endproperty
  a_mirror: assert property (p_mirror) else $error("pin and bit 10 differ");
  property p_sum; rd0_w |=> reg_rdata_o[10] == |reg_rdata_o[9:0]; endproperty
  a_sum: assert property (p_sum) else $error("bit 10 not OR of flags");
  property p_vds; rd0_w |=> reg_rdata_o[9] == |reg_rdata_o[5:0]; endproperty
  a_vds: assert property (p_vds) else $error("bit 9 not OR of switches");
  property p_latch; !error_indicator_pin_n_o && !$past(clr_w) |=> !error_indicator_pin_n_o;
  endproperty
  a_latch: assert property (p_latch) else $error("flag lost without clear");
  property p_idle; !reg_re_i |=> reg_rdata_o == 11'h000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_unmap;
    reg_re_i && reg_addr_i inside {4'h1, [4'h3:4'h5], [4'hA:4'hF]} |=> reg_rdata_o == 11'h000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst; $rose(nrst_i) |-> error_indicator_pin_n_o && reg_rdata_o == 11'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule : gdfsb_assertions
bind gdfsb_top gdfsb_assertions u_gdfsb_assertions (.*);

//--- testbench/gdfsb_ctrl_model.sv
// Purpose: controller side of the register port
// Assumes: one request at a time
// Notes:   idle lines carry the inverse of the last value
`timescale 1ns/1ps
module gdfsb_ctrl_model (
  // clock and read data
  input  wire logic                   clk_i,
  input  wire gdfsb_pkg::gdfsb_word_t rdata_i,
  // request
  output      gdfsb_pkg::gdfsb_addr_t addr_o,
  output      gdfsb_pkg::gdfsb_word_t wdata_o,
  output      logic                   we_o,
  output      logic                   re_o
);
  import gdfsb_pkg::*;
  initial begin
    addr_o = 4'hF;
    wdata_o = 11'h000;
    we_o = 1'b0;
    re_o = 1'b0;
  end
  task automatic wr(input gdfsb_addr_t a, input gdfsb_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    we_o <= 1'b1;
    @(posedge clk_i);
    we_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input gdfsb_addr_t a, output gdfsb_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge clk_i);
    re_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : gdfsb_ctrl_model

//--- testbench/gdfsb_top_tb.sv
// Purpose: register tests of the fault status bank
// Assumes: a mask bit of one passes its status bit to the interrupt
// Notes:   ev_q drives the detector inputs as levels
`timescale 1ns/1ps
module gdfsb_top_tb;
  import gdfsb_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [8:0]  ev_q = 9'h000;
  gdfsb_addr_t addr;
  gdfsb_word_t wdata, rdata, got;
  logic        we, re, pin_n, irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #4 core_clk_i = ~core_clk_i;
  gdfsb_top u_gdfsb_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .switch_overcurrent_i(ev_q[5:0]), .gate_drive_error_i(ev_q[6]),
    .supply_low_lockout_i(ev_q[7]), .overheat_shutdown_i(ev_q[8]),
    .error_indicator_pin_n_o(pin_n), .irq_o(irq));
  gdfsb_ctrl_model u_gdfsb_ctrl_model (.clk_i(core_clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re));
  task automatic chk(input string n, input gdfsb_word_t e, input gdfsb_word_t g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {10'h000, e}, {10'h000, g});
  endtask : bchk
  task automatic rchk(input gdfsb_addr_t a, input gdfsb_word_t e);
    u_gdfsb_ctrl_model.rd(a, got);
    chk("rdata", e, got);
  endtask : rchk
  task automatic settle;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask : settle
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rchk(4'h0, 11'h000);
    rchk(4'h9, 11'h000);
    bchk("pin", 1'b1, pin_n);
    u_gdfsb_ctrl_model.wr(4'h9, 11'h01F);
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk_i);
      ev_q <= 9'h001 << i;
      @(posedge core_clk_i);
      ev_q <= 9'h000;
      settle();
      bchk("pin", 1'b0, pin_n);
      bchk("irq", 1'b1, irq);
      u_gdfsb_ctrl_model.wr(4'h0, 11'h000);
      rchk(4'h0, i < 6 ? 11'h600 | 11'h001 << i : 11'h400 | 11'h001 << 14 - i);
      rchk(4'h8, i < 6 ? 11'h011 : 11'h001 | 11'h001 << 9 - i);
      u_gdfsb_ctrl_model.wr(4'h2, 11'h001);
      rchk(4'h0, 11'h000);
      rchk(4'h2, 11'h000);
      u_gdfsb_ctrl_model.wr(4'h8, 11'h01F);
      rchk(4'h8, 11'h000);
      settle();
      bchk("irq", 1'b0, irq);
      bchk("pin", 1'b1, pin_n);
    end
    @(posedge core_clk_i);
    ev_q <= 9'h001;
    u_gdfsb_ctrl_model.wr(4'h9, 11'h000);
    u_gdfsb_ctrl_model.wr(4'h2, 11'h001);
    rchk(4'h0, 11'h601);
    settle();
    bchk("irq", 1'b0, irq);
    rchk(4'h9, 11'h000);
    u_gdfsb_ctrl_model.wr(4'h9, 11'h01F);
    settle();
    bchk("irq", 1'b1, irq);
    @(posedge core_clk_i);
    ev_q <= 9'h000;
    u_gdfsb_ctrl_model.wr(4'h2, 11'h001);
    u_gdfsb_ctrl_model.wr(4'h8, 11'h01F);
    rchk(4'h0, 11'h000);
    // a flag set, then a reset in mid-run must clear it
    @(posedge core_clk_i);
    ev_q <= 9'h080;
    @(posedge core_clk_i);
    ev_q <= 9'h000;
    settle();
    bchk("pin", 1'b0, pin_n);
    rchk(4'h0, 11'h480);
    nrst_i <= 1'b0;
    settle();
    nrst_i <= 1'b1;
    rchk(4'h0, 11'h000);
    bchk("pin", 1'b1, pin_n);
    bchk("irq", 1'b0, irq);
    rchk(4'h9, 11'h000);
    u_gdfsb_ctrl_model.wr(4'h6, 11'h5A5);
    rchk(4'h6, 11'h5A5);
    u_gdfsb_ctrl_model.wr(4'h7, 11'h2C3);
    rchk(4'h7, 11'h2C3);
    rchk(4'h6, 11'h5A5);
    rchk(4'hF, 11'h000);
    close_out();
  end
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule : gdfsb_top_tb
